// [fws_pkg.sv]
// Purpose: Shared constants and types for the Flash write and erase sequencer.
// Assumes: One 10 MHz clock, asynchronous active-low reset.
// Notes: Register offsets are word addresses on the plain register port.
package fws_pkg;
  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [3:0] FWS_ADDR_CTRL = 4'h0;
  localparam logic [3:0] FWS_ADDR_KEY = 4'h1;
  localparam logic [3:0] FWS_ADDR_STAT = 4'h2;
  localparam logic [3:0] FWS_ADDR_RESET_SOURCE = 4'h3;
  localparam int FWS_CTRL_WE_BIT = 0;
  localparam int FWS_CTRL_EE_BIT = 1;
  localparam int FWS_STAT_BUSY_BIT = 0;
  localparam int FWS_STAT_BLOCKED_BIT = 1;
  localparam int FWS_STAT_UNLOCK_BIT = 2;
  localparam int FWS_RST_FERR_BIT = 6;
  localparam logic [7:0] FWS_CTRL_RESET = 8'h00;
  localparam logic [7:0] FWS_KEY_FIRST = 8'hA5;
  localparam logic [7:0] FWS_KEY_SECOND = 8'hF1;
  localparam logic [7:0] FWS_ERASED_BYTE = 8'hFF;
  // ****************************************
  // Memory geometry
  // ****************************************
  localparam logic [15:0] FWS_USER_TOP = 16'h7BFF;
  localparam logic [15:0] FWS_RESERVED_BASE = 16'h7C00;
  localparam int FWS_PAGE_BYTES = 1024;
  // ****************************************
  // Timing
  // ****************************************
  localparam int FWS_CLK_HZ = 10_000_000;
  localparam int FWS_WRITE_TIME_US = 40;
  localparam int FWS_ERASE_TIME_MS = 20;
  localparam int FWS_WRITE_CYCLES = (FWS_WRITE_TIME_US * (FWS_CLK_HZ / 1_000_000));
  localparam int FWS_ERASE_CYCLES = (FWS_ERASE_TIME_MS * (FWS_CLK_HZ / 1000));
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    FWS_IDLE = 4'h1,
    FWS_WRITE = 4'h2,
    FWS_ERASE = 4'h4,
    FWS_ERROR = 4'h8
  } fws_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } fws_reg_req_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fws_ext_req_t;
endpackage

// [fws_flash_mem.sv]
// Purpose: Byte-wide Flash array model with program-AND and page erase.
// Assumes: One access per cycle; erase walks one byte per cycle.
// Notes: Read data come out of a register one cycle after the request.
`timescale 1ns/100ps
module fws_flash_mem #(
  parameter int AW = 15
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rdEn,
  input wire logic [AW-1:0] rdAddr,
  output logic [7:0] rdData,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic clrEn,
  input wire logic [AW-1:0] clrAddr
);
  import fws_pkg::*;
  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] rdData_nxt;

  always_comb begin
    rdData_nxt = rdData;
    if (rdEn) begin
      rdData_nxt = mem[rdAddr];
    end
  end

  // Array contents carry no reset; the erase sequence sets them.
  always_ff @(posedge clock) begin
    if (clrEn) begin
      mem[clrAddr] <= FWS_ERASED_BYTE;
    end else if (wrEn) begin
      mem[wrAddr] <= mem[wrAddr] & wrData;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 8'h00;
    end else begin
      rdData <= rdData_nxt;
    end
  end
endmodule

// [fws_sequencer.sv]
// Purpose: Lock, key and timing sequencer for software Flash write and erase.
// Assumes: Core issues external-move and code-move requests one cycle wide.
// Notes: Flash error reset is a request pulse to the system reset controller.
`timescale 1ns/100ps
module fws_sequencer #(
  parameter int WRITE_CYCLES = fws_pkg::FWS_WRITE_CYCLES,
  parameter int ERASE_CYCLES = fws_pkg::FWS_ERASE_CYCLES,
  parameter int AW = 15
) (
  input wire logic clock,
  input wire logic rst_n,
  input fws_pkg::fws_reg_req_t regReq,
  output logic [7:0] regRdata,
  input fws_pkg::fws_ext_req_t extReq,
  output logic ramWrEn,
  output logic ramRdEn,
  output logic [15:0] ramAddr,
  output logic [7:0] ramWdata,
  input wire logic codeRd,
  input wire logic [15:0] codeAddr,
  output logic [7:0] codeData,
  input wire logic fetchMiss,
  output logic fetchStall,
  output logic irqHold,
  input wire logic supplyMonOn,
  input wire logic lastResetFlashErr,
  output logic flashErrReset,
  output logic flashBusy
);
  import fws_pkg::*;

  // ****************************************
  // State
  // ****************************************
  fws_state_t state_r, state_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic keyHalf_r, keyHalf_nxt;
  logic unlocked_r, unlocked_nxt;
  logic blocked_r, blocked_nxt;
  logic ferrFlag_r, ferrFlag_nxt;
  logic strapTaken_r, strapTaken_nxt;
  logic [31:0] count_r, count_nxt;
  logic [AW-1:0] opAddr_r, opAddr_nxt;
  logic [7:0] opData_r, opData_nxt;
  logic [7:0] regRdata_nxt;
  logic ramWrEn_nxt, ramRdEn_nxt;
  logic [15:0] ramAddr_nxt;
  logic [7:0] ramWdata_nxt;
  logic fetchStall_nxt, irqHold_nxt, flashErrReset_nxt, flashBusy_nxt;
  logic memWr, memClr;
  logic [AW-1:0] clrAddr;
  logic [AW-1:0] pageBase;

  // ****************************************
  // Decoding
  // ****************************************
  function automatic logic regHit(input fws_reg_req_t r, input logic [3:0] a);
    regHit = (r.addr == a);
  endfunction

  logic flashWrite;
  logic keyWr;
  logic ctrlWr;
  logic [7:0] statusByte;

  assign flashWrite = extReq.wr && ctrl_r[FWS_CTRL_WE_BIT];
  assign keyWr = regReq.wr && regHit(regReq, FWS_ADDR_KEY);
  assign ctrlWr = regReq.wr && regHit(regReq, FWS_ADDR_CTRL);
  assign pageBase = {opAddr_r[AW-1:10], 10'h000};
  assign clrAddr = pageBase | AW'(count_r[9:0]);
  assign memWr = (state_r == FWS_WRITE) && (count_r == 32'(WRITE_CYCLES - 1));
  assign memClr = (state_r == FWS_ERASE) && (count_r < 32'(FWS_PAGE_BYTES));
  assign statusByte = {5'h00, unlocked_r, blocked_r, flashBusy};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    keyHalf_nxt = keyHalf_r;
    unlocked_nxt = unlocked_r;
    blocked_nxt = blocked_r;
    ferrFlag_nxt = ferrFlag_r;
    strapTaken_nxt = 1'b1;
    count_nxt = count_r;
    opAddr_nxt = opAddr_r;
    opData_nxt = opData_r;
    flashErrReset_nxt = 1'b0;
    if (!strapTaken_r) begin
      ferrFlag_nxt = lastResetFlashErr;
    end
    if (ctrlWr) begin
      ctrl_nxt = regReq.wdata & 8'h03;
    end
    if (keyWr && !blocked_r) begin
      if (!keyHalf_r && !unlocked_r && regReq.wdata == FWS_KEY_FIRST) begin
        keyHalf_nxt = 1'b1;
      end else if (keyHalf_r && regReq.wdata == FWS_KEY_SECOND) begin
        keyHalf_nxt = 1'b0;
        unlocked_nxt = 1'b1;
      end else begin
        keyHalf_nxt = 1'b0;
        unlocked_nxt = 1'b0;
        blocked_nxt = 1'b1;
      end
    end
    unique case (state_r)
      FWS_IDLE: begin
        if (flashWrite) begin
          if (!supplyMonOn || extReq.addr > FWS_USER_TOP) begin
            flashErrReset_nxt = 1'b1;
            state_nxt = FWS_ERROR;
          end else if (!unlocked_r || blocked_r) begin
            blocked_nxt = 1'b1;
            keyHalf_nxt = 1'b0;
          end else begin
            opAddr_nxt = extReq.addr[AW-1:0];
            opData_nxt = extReq.wdata;
            count_nxt = 32'h0000_0000;
            state_nxt = ctrl_r[FWS_CTRL_EE_BIT] ? FWS_ERASE : FWS_WRITE;
          end
        end
      end
      FWS_WRITE: begin
        count_nxt = count_r + 32'h0000_0001;
        if (count_r == 32'(WRITE_CYCLES - 1)) begin
          state_nxt = FWS_IDLE;
          unlocked_nxt = 1'b0;
        end
      end
      FWS_ERASE: begin
        count_nxt = count_r + 32'h0000_0001;
        if (count_r == 32'(ERASE_CYCLES - 1)) begin
          state_nxt = FWS_IDLE;
          unlocked_nxt = 1'b0;
        end
      end
      FWS_ERROR: begin
        // Parks until the system reset controller pulls rst_n.
        state_nxt = FWS_ERROR;
      end
      default: begin
        state_nxt = FWS_IDLE;
      end
    endcase
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    regRdata_nxt = 8'h00;
    if (regReq.rd) begin
      unique case (regReq.addr)
        FWS_ADDR_CTRL: regRdata_nxt = ctrl_r;
        FWS_ADDR_STAT: regRdata_nxt = statusByte;
        FWS_ADDR_RESET_SOURCE: regRdata_nxt = 8'(ferrFlag_r) << FWS_RST_FERR_BIT;
        default: regRdata_nxt = 8'h00;
      endcase
    end
    ramWrEn_nxt = extReq.wr && !ctrl_r[FWS_CTRL_WE_BIT];
    ramRdEn_nxt = extReq.rd;
    ramAddr_nxt = extReq.addr;
    ramWdata_nxt = extReq.wdata;
    // Busy and stall follow the next state so they drop the cycle the count ends.
    flashBusy_nxt = (state_nxt == FWS_WRITE) || (state_nxt == FWS_ERASE);
    fetchStall_nxt = flashBusy_nxt && fetchMiss;
    irqHold_nxt = flashBusy_nxt;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= FWS_IDLE;
      ctrl_r <= FWS_CTRL_RESET;
      keyHalf_r <= 1'b0;
      unlocked_r <= 1'b0;
      blocked_r <= 1'b0;
      ferrFlag_r <= 1'b0;
      strapTaken_r <= 1'b0;
      count_r <= 32'h0000_0000;
      opAddr_r <= '0;
      opData_r <= 8'hFF;
      regRdata <= 8'h00;
      ramWrEn <= 1'b0;
      ramRdEn <= 1'b0;
      ramAddr <= 16'h0000;
      ramWdata <= 8'h00;
      fetchStall <= 1'b0;
      irqHold <= 1'b0;
      flashErrReset <= 1'b0;
      flashBusy <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      keyHalf_r <= keyHalf_nxt;
      unlocked_r <= unlocked_nxt;
      blocked_r <= blocked_nxt;
      ferrFlag_r <= ferrFlag_nxt;
      strapTaken_r <= strapTaken_nxt;
      count_r <= count_nxt;
      opAddr_r <= opAddr_nxt;
      opData_r <= opData_nxt;
      regRdata <= regRdata_nxt;
      ramWrEn <= ramWrEn_nxt;
      ramRdEn <= ramRdEn_nxt;
      ramAddr <= ramAddr_nxt;
      ramWdata <= ramWdata_nxt;
      fetchStall <= fetchStall_nxt;
      irqHold <= irqHold_nxt;
      flashErrReset <= flashErrReset_nxt;
      flashBusy <= flashBusy_nxt;
    end
  end

  // ****************************************
  // Flash array
  // ****************************************
  fws_flash_mem #(
    .AW(AW)
  ) u_mem (
    .clock(clock),
    .rst_n(rst_n),
    .rdEn(codeRd),
    .rdAddr(codeAddr[AW-1:0]),
    .rdData(codeData),
    .wrEn(memWr),
    .wrAddr(opAddr_r),
    .wrData(opData_r),
    .clrEn(memClr),
    .clrAddr(clrAddr)
  );
endmodule

// [fws_chk.sv]
// Purpose: Port-level assertions for the Flash write and erase sequencer.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes: The write-enable bit is mirrored from control register writes.
`timescale 1ns/100ps
module fws_chk #(
  parameter int WRITE_CYCLES = 4,
  parameter int ERASE_CYCLES = 1100
) (
  input wire logic clock,
  input wire logic rst_n,
  input fws_pkg::fws_reg_req_t regReq,
  input fws_pkg::fws_ext_req_t extReq,
  input wire logic fetchMiss,
  input wire logic fetchStall,
  input wire logic irqHold,
  input wire logic supplyMonOn,
  input wire logic flashErrReset,
  input wire logic flashBusy,
  input wire logic ramWrEn,
  input wire logic ramRdEn
);
  import fws_pkg::*;
  logic weBit_r, weBit_nxt;
  int busyCnt_r, busyCnt_nxt;
  // ****************************************
  // Helper state
  // ****************************************
  always_comb begin
    weBit_nxt = weBit_r;
    if (regReq.wr && regReq.addr == FWS_ADDR_CTRL) begin
      weBit_nxt = regReq.wdata[FWS_CTRL_WE_BIT];
    end
    busyCnt_nxt = flashBusy ? busyCnt_r + 1 : 0;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      weBit_r <= 1'b0;
      busyCnt_r <= 0;
    end else begin
      weBit_r <= weBit_nxt;
      busyCnt_r <= busyCnt_nxt;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence flashReq_s;
    extReq.wr && weBit_r && !flashBusy;
  endsequence
  AST_BUSY_LEN: assert property ($fell(flashBusy) |-> busyCnt_r inside {WRITE_CYCLES, ERASE_CYCLES})
    else $error("Busy period has the wrong length.");
  AST_BUSY_CAUSE: assert property ($rose(flashBusy) |-> $past(extReq.wr))
    else $error("Busy rose without a write.");
  AST_STALL: assert property ($past(fetchMiss) && fetchMiss && flashBusy |-> fetchStall)
    else $error("Fetch not stalled while busy.");
  AST_STALL_FREE: assert property (fetchStall |-> flashBusy)
    else $error("Fetch stalled while idle.");
  AST_IRQ: assert property (flashBusy |-> irqHold)
    else $error("Interrupts not held while busy.");
  AST_REDIRECT: assert property (extReq.wr |=> ramWrEn == !$past(weBit_r))
    else $error("Write went to the wrong target.");
  AST_RAM_RD: assert property (extReq.rd |=> ramRdEn)
    else $error("Read did not reach the data RAM.");
  AST_SUPPLY: assert property (flashReq_s ##0 !supplyMonOn |=> flashErrReset)
    else $error("No error reset with supply monitor off.");
  AST_RANGE: assert property (flashReq_s ##0 extReq.addr > FWS_USER_TOP |=> flashErrReset)
    else $error("No error reset above user space.");
  AST_ERR_CAUSE: assert property (flashErrReset |-> $past(extReq.wr))
    else $error("Error reset without a write.");
endmodule
bind fws_sequencer fws_chk #(.WRITE_CYCLES(WRITE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) i_fws_chk (.clock, .rst_n,
  .regReq, .extReq, .fetchMiss, .fetchStall, .irqHold, .supplyMonOn, .flashErrReset, .flashBusy, .ramWrEn, .ramRdEn);

// [fws_core_model.sv]
// Purpose: Processor core model issuing external-move and code-move requests.
// Assumes: Requests are one cycle wide, launched just after a rising edge.
// Notes: Released address and data lines carry the inverse of the last value.
`timescale 1ns/100ps
module fws_core_model (
  input wire logic clock,
  output fws_pkg::fws_ext_req_t extReq,
  output logic codeRd,
  output logic [15:0] codeAddr,
  input wire logic [7:0] codeData
);
  import fws_pkg::*;
  // This core raises no interrupts, so none can slip into a Flash sequence.
  initial begin
    extReq = '0;
    codeRd = 1'b0;
    codeAddr = 16'h0000;
  end
  task automatic extOp(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    extReq <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(posedge clock);
    extReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    #1;
  endtask
  task automatic codeRead(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    codeRd <= 1'b1;
    codeAddr <= a;
    @(posedge clock);
    codeRd <= 1'b0;
    codeAddr <= ~a;
    #1 d = codeData;
  endtask
endmodule

// [fws_sequencer_tb_top.sv]
// Purpose: Self-checking bench for the Flash write and erase sequencer.
// Assumes: Short write and erase counts so the run stays brief.
// Notes: Expected values follow the register map of the package.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %0t got %h exp %h", $time, g, e); end end
module fws_sequencer_tb_top;
  import fws_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic fetchMiss = 1'b0;
  logic supplyMonOn = 1'b1;
  logic lastResetFlashErr = 1'b0;
  fws_reg_req_t regReq = '0;
  fws_ext_req_t extReq;
  logic [7:0] regRdata, codeData, ramWdata, rd;
  logic codeRd, fetchStall, irqHold, flashErrReset, flashBusy, ramWrEn, ramRdEn;
  logic [15:0] codeAddr, ramAddr;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #50 clock = ~clock;
  fws_sequencer #(.WRITE_CYCLES(4), .ERASE_CYCLES(1100)) i_fws_sequencer (.clock, .rst_n, .regReq, .regRdata,
    .extReq, .ramWrEn, .ramRdEn, .ramAddr, .ramWdata, .codeRd, .codeAddr, .codeData, .fetchMiss, .fetchStall,
    .irqHold, .supplyMonOn, .lastResetFlashErr, .flashErrReset, .flashBusy);
  fws_core_model i_fws_core_model (.clock, .extReq, .codeRd, .codeAddr, .codeData);
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic regOp(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regReq <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(posedge clock);
    regReq <= '0;
    #1 rd = regRdata;
  endtask
  task automatic chkReg(input logic [3:0] a, input logic [7:0] e);
    regOp(1'b0, a, 8'h00);
    `CHK(rd, e)
  endtask
  task automatic chkCode(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_fws_core_model.codeRead(a, d);
    `CHK(d, e)
  endtask
  task automatic keys();
    regOp(1'b1, FWS_ADDR_KEY, FWS_KEY_FIRST);
    regOp(1'b1, FWS_ADDR_KEY, FWS_KEY_SECOND);
  endtask
  task automatic waitIdle();
    for (int i = 0; i < 1200 && flashBusy !== 1'b0; i++)
      @(negedge clock);
  endtask
  task automatic doReset(input logic ferr);
    @(posedge clock);
    rst_n <= 1'b0;
    lastResetFlashErr <= ferr;
    supplyMonOn <= 1'b1;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    doReset(1'b0);
    chkReg(FWS_ADDR_CTRL, FWS_CTRL_RESET);
    chkReg(FWS_ADDR_RESET_SOURCE, 8'h00);
    chkReg(4'hF, 8'h00);
    keys();
    chkReg(FWS_ADDR_STAT, 8'h04);
    regOp(1'b1, FWS_ADDR_CTRL, 8'h02);
    regOp(1'b1, FWS_ADDR_CTRL, 8'h03);
    i_fws_core_model.extOp(1'b1, 16'h0155, 8'h00);
    `CHK(irqHold, 1'b1)
    waitIdle();
    `CHK(irqHold, 1'b0)
    chkReg(FWS_ADDR_STAT, 8'h00);
    chkReg(FWS_ADDR_CTRL, 8'h03);
    regOp(1'b1, FWS_ADDR_CTRL, 8'h01);
    chkCode(16'h0000, FWS_ERASED_BYTE);
    chkCode(16'h03FF, FWS_ERASED_BYTE);
    @(posedge clock);
    fetchMiss <= 1'b1;
    keys();
    i_fws_core_model.extOp(1'b1, 16'h0155, 8'h3C);
    `CHK(fetchStall, 1'b1)
    waitIdle();
    `CHK(fetchStall, 1'b0)
    chkCode(16'h0155, 8'h3C);
    keys();
    i_fws_core_model.extOp(1'b1, 16'h0155, 8'hF0);
    waitIdle();
    chkCode(16'h0155, 8'h30);
    i_fws_core_model.extOp(1'b1, 16'h0155, 8'h00);
    `CHK(flashBusy, 1'b0)
    keys();
    chkReg(FWS_ADDR_STAT, 8'h02);
    regOp(1'b1, FWS_ADDR_CTRL, 8'h00);
    i_fws_core_model.extOp(1'b1, 16'h0155, 8'hAA);
    `CHK(ramWrEn, 1'b1)
    `CHK(ramAddr, 16'h0155)
    `CHK(ramWdata, 8'hAA)
    i_fws_core_model.extOp(1'b0, 16'h0155, 8'h00);
    `CHK(ramRdEn, 1'b1)
    for (int i = 0; i < 2; i++) begin
      doReset(1'b0);
      if (i == 1) begin
        regOp(1'b1, FWS_ADDR_KEY, FWS_KEY_FIRST);
      end
      regOp(1'b1, FWS_ADDR_KEY, i ? 8'h11 : FWS_KEY_SECOND);
      chkReg(FWS_ADDR_STAT, 8'h02);
    end
    for (int i = 0; i < 2; i++) begin
      doReset(1'b0);
      supplyMonOn <= i[0];
      keys();
      regOp(1'b1, FWS_ADDR_CTRL, 8'h01);
      i_fws_core_model.extOp(1'b1, i ? FWS_RESERVED_BASE : 16'h0155, 8'h00);
      `CHK(flashErrReset, 1'b1)
    end
    doReset(1'b1);
    chkReg(FWS_ADDR_RESET_SOURCE, 8'h40);
    print_verdict();
  end
endmodule
